// *** hdl/ptc_pkg.sv ***
// Package for the pulse-generator timer channel: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package ptc_pkg;
  localparam int unsigned PTC_AW = 6;
  localparam logic [5:0] PTC_OFS_ENABLE = 6'h00;
  localparam logic [5:0] PTC_OFS_RUN = 6'h04;
  localparam logic [5:0] PTC_OFS_CTRL = 6'h08;
  localparam logic [5:0] PTC_OFS_MODE = 6'h0c;
  localparam logic [5:0] PTC_OFS_FLOP = 6'h10;
  localparam logic [5:0] PTC_OFS_MASK = 6'h14;
  localparam logic [5:0] PTC_OFS_CMP0 = 6'h18;
  localparam logic [5:0] PTC_OFS_CMP1 = 6'h1c;
  localparam logic [5:0] PTC_OFS_CAP0 = 6'h20;
  localparam logic [5:0] PTC_OFS_CAP1 = 6'h24;
  localparam logic [5:0] PTC_OFS_COUNT = 6'h28;
  localparam logic [5:0] PTC_OFS_STATUS = 6'h2c;
  // Run register bits
  localparam int unsigned PTC_RUN_CNT = 0;
  localparam int unsigned PTC_RUN_PRE = 2;
  // Channel control bits
  localparam int unsigned PTC_CR_DBUF = 7;
  localparam int unsigned PTC_CR_TRGSTART = 6;
  localparam int unsigned PTC_CR_TRGEDGE = 2;
  // Mode register fields
  localparam int unsigned PTC_MOD_CLK_LSB = 0;
  localparam int unsigned PTC_MOD_CPM_LSB = 4;
  localparam int unsigned PTC_MOD_SWCAP = 6;
  // Flop control fields
  localparam int unsigned PTC_FF_CMD_LSB = 0;
  localparam int unsigned PTC_FF_EN0 = 2;
  localparam int unsigned PTC_FF_EN1 = 3;
  localparam logic [1:0] PTC_FF_INVERT = 2'h0;
  localparam logic [1:0] PTC_FF_SET = 2'h1;
  localparam logic [1:0] PTC_FF_CLEAR = 2'h2;
  localparam logic [1:0] PTC_CPM_PAIRED = 2'h3;
  localparam logic [7:0] PTC_MODE_RST = 8'h40;
  localparam logic [7:0] PTC_FLOP_RST = 8'h03;
  localparam logic [2:0] PTC_MASK_RST = 3'h7;
  localparam logic [2:0] PTC_CLK_EXT = 3'h0;
  localparam logic [15:0] PTC_CNT_RST = 16'h0000;
  localparam int unsigned PTC_PRE_W = 8;
  typedef enum logic [1:0] {PTC_STOPPED, PTC_WAITING, PTC_COUNTING} ptc_run_t;
endpackage

// *** hdl/ptc_sync.sv ***
// Two-stage synchroniser for one pin level.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/100ps
module ptc_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Data
  input wire logic d_in,
  output logic q_out
);
  logic s1_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_q <= d_in;
      q_out <= s1_q;
    end
  end
endmodule

// *** hdl/ptc_prescaler.sv ***
// Free prescaler producing one-cycle tap pulses at clk/1 .. clk/128.
// Assumes an active-low reset from the parent, asserted asynchronously and released synchronously.
`timescale 1ns/100ps
module ptc_prescaler
  import ptc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  logic [PTC_PRE_W-1:0] cnt_q;
  logic [PTC_PRE_W-1:0] cnt_d;
  logic [PTC_PRE_W-1:0] mask;
  always_comb begin
    cnt_d = run_in ? cnt_q + 8'h01 : 8'h00;
    mask = 8'(({1'b0, 7'h7f} >> (3'd7 - sel_in)));
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // Tap n fires once every 2^n cycles while running
      tick_out <= run_in && ((cnt_q & mask) == mask);
    end
  end
endmodule

// *** hdl/ptc_timer.sv ***
// Pulse-generator timer channel with compare, double buffer, trigger start and capture.
// Assumes AXI4-Lite master on clk_in; pins asynchronous; paired flop from a sibling channel.
`timescale 1ns/100ps
module ptc_timer
  import ptc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Pins and pairing
  input wire logic timer_input_pin_in,
  input wire logic paired_flop_in,
  output logic timer_output_pin_out,
  output logic match_interrupt_out,
  // AXI4-Lite write
  input wire logic [ptc_pkg::PTC_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [ptc_pkg::PTC_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import ptc_pkg::*;

  typedef struct packed {
    logic enable;
    logic [2:0] run;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] flop;
    logic [2:0] mask;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] buf0;
    logic [15:0] buf1;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic [15:0] count;
    ptc_run_t state;
    logic ff;
    logic pin_prev;
    logic pair_prev;
    logic [2:0] events;
    logic irq;
    logic aw_held;
    logic [PTC_AW-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ptc_state_t;

  ptc_state_t s_q;
  ptc_state_t s_d;
  logic rst_s1_q;
  logic rst_b_q;
  logic pin_sync;
  logic pair_sync;
  logic tap_tick;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q <= rst_s1_q;
    end
  end

  ptc_sync u_pin_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_q),
    .d_in(timer_input_pin_in),
    .q_out(pin_sync)
  );
  ptc_sync u_pair_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_q),
    .d_in(paired_flop_in),
    .q_out(pair_sync)
  );
  ptc_prescaler u_pre (
    .clk_in(clk_in),
    .rst_b_in(rst_b_q),
    .run_in(s_q.enable && s_q.run[PTC_RUN_PRE]),
    .sel_in(s_q.mode[PTC_MOD_CLK_LSB +: 3]),
    .tick_out(tap_tick)
  );

  logic pin_rise;
  logic pin_fall;
  logic trig_edge;
  logic cnt_tick;
  logic hit0;
  logic hit1;
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rval;
  logic rerr;
  logic werr;
  logic cnt_run;

  always_comb begin
    s_d = s_q;
    pin_rise = pin_sync && !s_q.pin_prev;
    pin_fall = !pin_sync && s_q.pin_prev;
    trig_edge = s_q.ctrl[PTC_CR_TRGEDGE] ? pin_fall : pin_rise;
    cnt_run = s_q.enable && s_q.run[PTC_RUN_CNT] && s_q.run[PTC_RUN_PRE];
    // Rising pin edges count in event mode, prescaler taps otherwise
    cnt_tick = (s_q.mode[PTC_MOD_CLK_LSB +: 3] == PTC_CLK_EXT) ? pin_rise : tap_tick;
    hit0 = (s_q.state == PTC_COUNTING) && cnt_tick && (s_q.count == s_q.cmp0);
    hit1 = (s_q.state == PTC_COUNTING) && cnt_tick && (s_q.count == s_q.cmp1);
    s_d.pin_prev = pin_sync;
    s_d.pair_prev = pair_sync;
    s_d.irq = 1'b0;
    s_d.events = 3'h0;

    case (s_q.state)
      PTC_STOPPED: begin
        if (cnt_run) begin
          s_d.state = s_q.ctrl[PTC_CR_TRGSTART] ? PTC_WAITING : PTC_COUNTING;
        end
      end
      PTC_WAITING: begin
        if (!cnt_run) begin
          s_d.state = PTC_STOPPED;
        end else if (trig_edge) begin
          s_d.state = PTC_COUNTING;
        end
      end
      PTC_COUNTING: begin
        if (!cnt_run) begin
          s_d.state = PTC_STOPPED;
        end else if (cnt_tick) begin
          s_d.count = s_q.count + 16'h0001;
        end
      end
      default: s_d.state = PTC_STOPPED;
    endcase
    if (!cnt_run) begin
      s_d.count = PTC_CNT_RST;
    end

    // Matches toggle the flop; the pin follows it
    if ((hit0 && s_q.flop[PTC_FF_EN0]) ^ (hit1 && s_q.flop[PTC_FF_EN1])) begin
      s_d.ff = !s_q.ff;
    end
    // Buffers take effect only at the period end so a cycle is never torn
    if (hit1 && s_q.ctrl[PTC_CR_DBUF]) begin
      s_d.cmp0 = s_q.buf0;
      s_d.cmp1 = s_q.buf1;
    end
    // Mask bit 1 guards the second match and bit 2 the first, so 101 passes only the period end
    s_d.events = {hit0, hit1, 1'b0};
    s_d.irq = |(s_d.events & ~s_q.mask);

    // Paired channel flop edges latch the counter
    if (s_q.mode[PTC_MOD_CPM_LSB +: 2] == PTC_CPM_PAIRED) begin
      if (pair_sync && !s_q.pair_prev) begin
        s_d.cap0 = s_q.count;
      end
      if (!pair_sync && s_q.pair_prev) begin
        s_d.cap1 = s_q.count;
      end
    end

    // Bus write channel
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid_in && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_q.wstrb[i]}};
    end
    werr = 1'b0;
    wval = 32'h0;
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      if (s_q.awaddr == PTC_OFS_ENABLE) begin
        wval = (32'(s_q.enable) << 7 & ~wmask) | (s_q.wdata & wmask);
        s_d.enable = wval[7];
      end else if (s_q.awaddr == PTC_OFS_RUN) begin
        wval = (32'(s_q.run) & ~wmask) | (s_q.wdata & wmask);
        s_d.run = wval[2:0];
      end else if (s_q.awaddr == PTC_OFS_CTRL) begin
        wval = (32'(s_q.ctrl) & ~wmask) | (s_q.wdata & wmask);
        s_d.ctrl[PTC_CR_DBUF] = wval[PTC_CR_DBUF];
        // Trigger options change only while stopped
        if (s_q.state == PTC_STOPPED) begin
          s_d.ctrl[PTC_CR_TRGSTART] = wval[PTC_CR_TRGSTART];
          s_d.ctrl[PTC_CR_TRGEDGE] = wval[PTC_CR_TRGEDGE];
        end
      end else if (s_q.awaddr == PTC_OFS_MODE) begin
        wval = (32'(s_q.mode) & ~wmask) | (s_q.wdata & wmask);
        s_d.mode = wval[7:0];
        // Writing 0 to the soft-capture bit latches the counter
        if (s_q.wstrb[0] && !wval[PTC_MOD_SWCAP]) begin
          s_d.cap0 = s_q.count;
        end
      end else if (s_q.awaddr == PTC_OFS_FLOP) begin
        wval = (32'(s_q.flop) & ~wmask) | (s_q.wdata & wmask);
        s_d.flop = wval[7:0];
        if (s_q.wstrb[0]) begin
          case (wval[PTC_FF_CMD_LSB +: 2])
            PTC_FF_INVERT: s_d.ff = !s_q.ff;
            PTC_FF_SET: s_d.ff = 1'b1;
            PTC_FF_CLEAR: s_d.ff = 1'b0;
            default: s_d.ff = s_d.ff;
          endcase
        end
      end else if (s_q.awaddr == PTC_OFS_MASK) begin
        wval = (32'(s_q.mask) & ~wmask) | (s_q.wdata & wmask);
        s_d.mask = wval[2:0];
      end else if (s_q.awaddr == PTC_OFS_CMP0) begin
        wval = (32'(s_q.buf0) & ~wmask) | (s_q.wdata & wmask);
        s_d.buf0 = wval[15:0];
        if (!s_q.ctrl[PTC_CR_DBUF] || s_q.state == PTC_STOPPED) begin
          s_d.cmp0 = wval[15:0];
        end
      end else if (s_q.awaddr == PTC_OFS_CMP1) begin
        wval = (32'(s_q.buf1) & ~wmask) | (s_q.wdata & wmask);
        s_d.buf1 = wval[15:0];
        if (!s_q.ctrl[PTC_CR_DBUF] || s_q.state == PTC_STOPPED) begin
          s_d.cmp1 = wval[15:0];
        end
      end else begin
        werr = 1'b1;
      end
      s_d.bresp = werr ? 2'h2 : 2'h0;
    end

    // Bus read channel
    if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    rd_go = s_axi_arvalid_in && !s_q.rvalid;
    rerr = 1'b0;
    rval = 32'h0;
    if (s_axi_araddr_in == PTC_OFS_ENABLE) begin
      rval = 32'(s_q.enable) << 7;
    end else if (s_axi_araddr_in == PTC_OFS_RUN) begin
      rval = 32'(s_q.run);
    end else if (s_axi_araddr_in == PTC_OFS_CTRL) begin
      rval = 32'(s_q.ctrl);
    end else if (s_axi_araddr_in == PTC_OFS_MODE) begin
      rval = 32'(s_q.mode);
    end else if (s_axi_araddr_in == PTC_OFS_FLOP) begin
      rval = 32'(s_q.flop[3:2]) << 2;
    end else if (s_axi_araddr_in == PTC_OFS_MASK) begin
      rval = 32'(s_q.mask);
    end else if (s_axi_araddr_in == PTC_OFS_CMP0) begin
      rval = 32'(s_q.cmp0);
    end else if (s_axi_araddr_in == PTC_OFS_CMP1) begin
      rval = 32'(s_q.cmp1);
    end else if (s_axi_araddr_in == PTC_OFS_CAP0) begin
      rval = 32'(s_q.cap0);
    end else if (s_axi_araddr_in == PTC_OFS_CAP1) begin
      rval = 32'(s_q.cap1);
    end else if (s_axi_araddr_in == PTC_OFS_COUNT) begin
      rval = 32'(s_q.count);
    end else if (s_axi_araddr_in == PTC_OFS_STATUS) begin
      rval = {28'h0, s_q.ff, 1'b0, 2'(s_q.state)};
    end else begin
      rerr = 1'b1;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rval;
      s_d.rresp = rerr ? 2'h2 : 2'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      s_q <= '0;
      s_q.state <= PTC_STOPPED;
      s_q.mode <= PTC_MODE_RST;
      s_q.flop <= PTC_FLOP_RST;
      s_q.mask <= PTC_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    timer_output_pin_out = s_q.ff;
    match_interrupt_out = s_q.irq;
    s_axi_awready_out = !s_q.aw_held;
    s_axi_wready_out = !s_q.w_held;
    s_axi_bvalid_out = s_q.bvalid;
    s_axi_bresp_out = s_q.bresp;
    s_axi_arready_out = !s_q.rvalid;
    s_axi_rvalid_out = s_q.rvalid;
    s_axi_rdata_out = s_q.rdata;
    s_axi_rresp_out = s_q.rresp;
  end

  match_toggle_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (hit0 && s_q.flop[PTC_FF_EN0] && !hit1 && !wr_go) |=> (s_q.ff != $past(s_q.ff)))
    else $error("flop did not toggle on first match");
  stop_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    !cnt_run |=> (s_q.count == 16'h0000))
    else $error("counter not cleared while stopped");
  buf_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (hit1 && s_q.ctrl[PTC_CR_DBUF] && !wr_go) |=> (s_q.cmp1 == $past(s_q.buf1)))
    else $error("buffer not loaded at second match");
  trig_wait_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (s_q.state == PTC_WAITING && cnt_run && !trig_edge) |=> (s_q.state == PTC_WAITING))
    else $error("counter left wait without trigger");
  irq_mask_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (s_q.mask == 3'h5 && hit0 && !hit1) |=> !match_interrupt_out)
    else $error("masked first match raised interrupt");
  pin_follow_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    $changed(timer_output_pin_out)
    |-> $past(hit0 || hit1 || (wr_go && s_q.awaddr == PTC_OFS_FLOP)))
    else $error("output pin moved without match or flop command");
  count_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (s_q.state == PTC_COUNTING && cnt_run && cnt_tick)
    |=> (s_q.count == 16'($past(s_q.count) + 16'h0001)))
    else $error("counter did not step");
  direct_cmp_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (wr_go && s_q.awaddr == PTC_OFS_CMP0 && s_q.wstrb == 4'hf && s_q.state == PTC_STOPPED)
    |=> (s_q.cmp0 == $past(s_q.wdata[15:0])))
    else $error("stopped compare write not direct");
  pair_cap_a: assert property (@(posedge clk_in) disable iff (!rst_b_q)
    (s_q.mode[5:4] == 2'h3 && pair_sync && !s_q.pair_prev && !wr_go)
    |=> (s_q.cap0 == $past(s_q.count)))
    else $error("capture missed paired rising edge");
endmodule

// *** tb/ptc_far_end.sv ***
// Far-side model: pulse source on the input pin, sibling flop level, load measuring output pulses.
// Assumes one clock shared with the bench; all pin changes land just after a rising edge.
`timescale 1ns/100ps
module ptc_far_end (
  // Clock
  input wire logic clk_in,
  // Pins
  input wire logic timer_output_pin_in,
  output logic timer_input_pin_out,
  output logic paired_flop_out
);
  int run_len = 0;
  int high_len = 0;
  int fall_count = 0;

  // Source idles low between pulses, like an undriven pin with a pull-down
  initial begin
    timer_input_pin_out = 1'b0;
    paired_flop_out = 1'b0;
  end

  // Load side: width in clocks of the last completed high pulse
  always @(posedge clk_in) begin
    if (timer_output_pin_in === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      high_len <= run_len;
      fall_count <= fall_count + 1;
      run_len <= 0;
    end
  end

  task automatic pulses(input int n, input int half);
    repeat (n) begin
      @(posedge clk_in);
      timer_input_pin_out <= 1'b1;
      repeat (half) @(posedge clk_in);
      timer_input_pin_out <= 1'b0;
      repeat (half) @(posedge clk_in);
    end
  endtask

  task automatic set_input(input logic v);
    @(posedge clk_in);
    timer_input_pin_out <= v;
  endtask

  task automatic set_pair(input logic v);
    @(posedge clk_in);
    paired_flop_out <= v;
  endtask
endmodule

// *** tb/ppg_timer_with_capture_tb.sv ***
// Bench for the pulse-generator timer channel: AXI4-Lite register tasks and pin scenarios.
// Assumes the far-side model drives the input and paired pins and measures output pulses.
`timescale 1ns/100ps
module ppg_timer_with_capture_tb;
  import ptc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic in_pin, pair, out_pin, irq;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [1:0] cmd [4] = '{PTC_FF_SET, PTC_FF_CLEAR, PTC_FF_INVERT, PTC_FF_INVERT};
  logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int fail_count = 0, total_checks = 0, cycles = 0, irq_count = 0, n0 = 0;

  always #20 clk_in = ~clk_in;

  ptc_timer ptc_timer_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .timer_input_pin_in(in_pin), .paired_flop_in(pair), .timer_output_pin_out(out_pin),
    .match_interrupt_out(irq), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1));

  ptc_far_end ptc_far_end_inst (.clk_in(clk_in), .timer_output_pin_in(out_pin),
    .timer_input_pin_out(in_pin), .paired_flop_out(pair));

  always @(posedge clk_in) if (irq === 1'b1) irq_count++;

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR run length expected finish seen timeout");
      close_out();
    end
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Both channels offered together; each released at the edge that takes it
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_in);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_in);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk_in);
      if (ta) arvalid <= 1'b0;
    end
  endtask

  task automatic rc(input string what, input logic [5:0] a, input logic [31:0] exp);
    rd_reg(a, rd);
    check(what, exp, rd);
  endtask

  task automatic pin_is(input logic exp);
    @(negedge clk_in);
    check("output pin", {31'h0, exp}, {31'h0, out_pin});
    @(posedge clk_in);
  endtask

  task automatic wait_fall();
    int k;
    k = 0;
    while (ptc_far_end_inst.fall_count == n0 && k < 2000) begin
      @(posedge clk_in);
      k++;
    end
    check("pulse seen", 1, ptc_far_end_inst.fall_count - n0);
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    pin_is(1'b0);
    rc("mode reset", PTC_OFS_MODE, {24'h0, PTC_MODE_RST});
    rc("mask reset", PTC_OFS_MASK, {29'h0, PTC_MASK_RST});
    rc("count reset", PTC_OFS_COUNT, {16'h0, PTC_CNT_RST});
    rd_reg(PTC_OFS_CTRL, rd);
    check("buffer off", 32'h0, {31'h0, rd[PTC_CR_DBUF]});
    rd_reg(6'h30, rd);
    check("unmapped read", 32'h2, {30'h0, resp});
    wr(6'h30, 32'h5);
    check("unmapped write", 32'h2, {30'h0, resp});
    for (int i = 0; i < 4; i++) begin
      wr(PTC_OFS_FLOP, {30'h0, cmd[i]});
      pin_is(ex[i]);
    end
    // Plain pulse output from the first tap, every interrupt masked
    wr(PTC_OFS_ENABLE, 32'h80);
    wr(PTC_OFS_CMP0, 32'h3);
    wr(PTC_OFS_CMP1, 32'h7);
    wr(PTC_OFS_FLOP, 32'he);
    wr(PTC_OFS_MODE, 32'h41);
    n0 = ptc_far_end_inst.fall_count;
    wr(PTC_OFS_RUN, 32'h5);
    wait_fall();
    check("pulse width", 8, ptc_far_end_inst.high_len);
    check("masked irq", 0, irq_count);
    wr(PTC_OFS_RUN, 32'h0);
    rc("count after stop", PTC_OFS_COUNT, 32'h0);
    // Buffered compares: new values written right after start wait for the second match
    wr(PTC_OFS_CTRL, 32'h80);
    wr(PTC_OFS_CMP0, 32'h2);
    wr(PTC_OFS_CMP1, 32'h5);
    wr(PTC_OFS_FLOP, 32'he);
    wr(PTC_OFS_MODE, 32'h43);
    n0 = ptc_far_end_inst.fall_count;
    wr(PTC_OFS_RUN, 32'h5);
    wr(PTC_OFS_CMP0, 32'ha);
    wr(PTC_OFS_CMP1, 32'h14);
    wait_fall();
    check("first buffered width", 24, ptc_far_end_inst.high_len);
    n0 = ptc_far_end_inst.fall_count;
    wait_fall();
    check("second buffered width", 80, ptc_far_end_inst.high_len);
    wr(PTC_OFS_RUN, 32'h0);
    // Delayed one-shot from a rising trigger edge
    wr(PTC_OFS_CTRL, 32'h40);
    wr(PTC_OFS_MASK, 32'h5);
    wr(PTC_OFS_CMP0, 32'h4);
    wr(PTC_OFS_CMP1, 32'h9);
    wr(PTC_OFS_FLOP, 32'he);
    wr(PTC_OFS_MODE, 32'h41);
    wr(PTC_OFS_RUN, 32'h5);
    repeat (20) @(posedge clk_in);
    rd_reg(PTC_OFS_STATUS, rd);
    check("waiting state", 32'h1, {30'h0, rd[1:0]});
    rc("count while waiting", PTC_OFS_COUNT, 32'h0);
    n0 = ptc_far_end_inst.fall_count;
    ptc_far_end_inst.pulses(1, 4);
    while (out_pin !== 1'b1) @(posedge clk_in);
    repeat (3) @(posedge clk_in);
    check("first match irq masked", 0, irq_count);
    wait_fall();
    check("one-shot width", 10, ptc_far_end_inst.high_len);
    repeat (4) @(posedge clk_in);
    check("second match irq only", 1, irq_count);
    rd_reg(PTC_OFS_STATUS, rd);
    check("counting state", 32'h2, {30'h0, rd[1:0]});
    wr(PTC_OFS_CTRL, 32'h44);
    rd_reg(PTC_OFS_CTRL, rd);
    check("edge locked while running", 32'h0, {31'h0, rd[PTC_CR_TRGEDGE]});
    wr(PTC_OFS_FLOP, 32'h3);
    wr(PTC_OFS_RUN, 32'h0);
    wr(PTC_OFS_CTRL, 32'h0);
    // Event counting on pin edges with capture on the sibling flop edges
    wr(PTC_OFS_MODE, 32'h70);
    wr(PTC_OFS_RUN, 32'h5);
    ptc_far_end_inst.pulses(3, 4);
    repeat (5) @(posedge clk_in);
    rc("event count", PTC_OFS_COUNT, 32'h3);
    ptc_far_end_inst.set_pair(1'b1);
    repeat (5) @(posedge clk_in);
    ptc_far_end_inst.pulses(4, 4);
    ptc_far_end_inst.set_pair(1'b0);
    repeat (5) @(posedge clk_in);
    rc("capture on rise", PTC_OFS_CAP0, 32'h3);
    rc("capture on fall", PTC_OFS_CAP1, 32'h7);
    // Writing 0 to the soft-capture bit latches the running event count
    wr(PTC_OFS_MODE, 32'h30);
    rc("soft capture", PTC_OFS_CAP0, 32'h7);
    // Falling-edge trigger: a rising edge alone must leave the counter waiting
    wr(PTC_OFS_RUN, 32'h0);
    wr(PTC_OFS_CTRL, 32'h44);
    wr(PTC_OFS_MODE, 32'h41);
    wr(PTC_OFS_RUN, 32'h5);
    ptc_far_end_inst.set_input(1'b1);
    repeat (5) @(posedge clk_in);
    rd_reg(PTC_OFS_STATUS, rd);
    check("waiting past rising edge", 32'h1, {30'h0, rd[1:0]});
    ptc_far_end_inst.set_input(1'b0);
    repeat (5) @(posedge clk_in);
    rd_reg(PTC_OFS_STATUS, rd);
    check("counting after falling edge", 32'h2, {30'h0, rd[1:0]});
    close_out();
  end
endmodule
